// ### branch_ccr_pkg.sv
package branch_ccr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_CCR = 8'h0C;
  localparam logic [7:0] OFS_GENREG = 8'h10;
  localparam logic [7:0] OFS_PORTDR = 8'h14;
  localparam logic [7:0] OFS_PORTDDR = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // Status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SLEEP_BIT = 1;
  localparam int ST_TAKEN_BIT = 2;
  localparam int ST_DEPTH_LSB = 4;

  // Opcodes of the instruction register
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_BCC = 4'h1;
  localparam logic [3:0] OP_JUMP = 4'h2;
  localparam logic [3:0] OP_CALL_ABS = 4'h3;
  localparam logic [3:0] OP_CALL_REL = 4'h4;
  localparam logic [3:0] OP_RTS = 4'h5;
  localparam logic [3:0] OP_TRAP = 4'h6;
  localparam logic [3:0] OP_EXC_RET = 4'h7;
  localparam logic [3:0] OP_SLEEP = 4'h8;
  localparam logic [3:0] OP_LOADF_IMM = 4'h9;
  localparam logic [3:0] OP_LOADF_REG = 4'hA;
  localparam logic [3:0] OP_STOREF = 4'hB;
  localparam logic [3:0] OP_ANDF = 4'hC;
  localparam logic [3:0] OP_ORF = 4'hD;
  localparam logic [3:0] OP_XORF = 4'hE;
  localparam logic [3:0] OP_BITCLR = 4'hF;

  // Flag positions inside the condition code register
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int CCR_I = 7;

  // Reset values and fixed steps
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [7:0] DDR_READ_VALUE = 8'hFF;

  // Instruction word, low 20 bits of the bus write
  typedef struct packed {
    logic [7:0] imm;
    logic [3:0] cond;
    logic [2:0] bitNum;
    logic toPort;
    logic [3:0] op;
  } instr_t;

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_MODIFY, ST_WRITE, ST_SLEEP} state_t;
endpackage

// ### cond_eval.sv
// Branch condition evaluation from flags
module cond_eval (
  input wire logic [3:0] branchConditionField,
  input wire logic [7:0] ccr,
  output logic taken
);
  logic nv;
  logic base;

  // Pairs of codes share one term; low bit picks =1 or =0
  always_comb begin
    nv = ccr[branch_ccr_pkg::CCR_N] ^ ccr[branch_ccr_pkg::CCR_V];
    case (branchConditionField[3:1])
      3'h0: base = 1'b0;
      3'h1: base = ccr[branch_ccr_pkg::CCR_C] | ccr[branch_ccr_pkg::CCR_Z];
      3'h2: base = ccr[branch_ccr_pkg::CCR_C];
      3'h3: base = ccr[branch_ccr_pkg::CCR_Z];
      3'h4: base = ccr[branch_ccr_pkg::CCR_V];
      3'h5: base = ccr[branch_ccr_pkg::CCR_N];
      3'h6: base = nv;
      3'h7: base = ccr[branch_ccr_pkg::CCR_Z] | nv;
      default: base = 1'b0;
    endcase
    taken = branchConditionField[0] ? base : !base;
  end
endmodule // cond_eval

// ### port_io_unit.sv
// Port with write-only direction register
module port_io_unit #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ddrWe,
  input wire logic [W-1:0] ddrData,
  input wire logic drWe,
  input wire logic [W-1:0] drData,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] ddrRead,
  output logic [W-1:0] drRead,
  output logic [W-1:0] pinOut,
  output logic [W-1:0] pinOe
);
  logic [W-1:0] ddr, next_ddr, dr, next_dr, syncA, syncB;

  // Direction and data next values
  always_comb begin
    next_ddr = ddrWe ? ddrData : ddr;
    next_dr = drWe ? drData : dr;
  end

  // Registers and two-stage pin synchroniser
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ddr <= '0;
      dr <= '0;
      syncA <= '0;
      syncB <= '0;
    end else begin
      ddr <= next_ddr;
      dr <= next_dr;
      syncA <= pinIn;
      syncB <= syncA;
    end
  end

  // Direction bit 1 drives, 0 listens
  assign pinOut = dr;
  assign pinOe = ddr;
  assign ddrRead = '1;
  assign drRead = (dr & ddr) | (syncB & ~ddr);
endmodule // port_io_unit

// ### branch_and_ccr_control_exec.sv
// Operation
// - Reading the port direction register always returns all ones.
// - Bit clear clears only the chosen bit of the byte read.
// - Bit clear writes the whole modified byte back to same place.
// - Direction bit 0 makes pin input, 1 drives its data bit.
// - Branch codes 0000 always, 0001 never, 0010/0011 on carry OR zero.
// - Codes 0100 to 1011 test carry, zero, overflow, negative clear or set.
// - Jump goes to the target address without testing flags.
// - Calls go absolute or relative and save the following address only while the stack is not full.
// - Exception return restores the interrupted flow and flags.
// - Sleep moves the processor into the power-down state.
// - Load-flags puts an immediate or general register byte in flags.
// - Store-flags copies the flags byte into the general register.
// - AND-flags replaces flags with flags AND immediate byte.
// - OR-flags replaces flags with flags OR immediate byte.
// - XOR-flags replaces flags with flags XOR immediate byte.
// - No-operation only advances the program counter by two.
// - Bit modify reads, then modifies, then writes back, in order.
//
// Implementation choices: the APB slave port and the placing of the registers.
module branch_and_ccr_control_exec #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] portIn,
  output logic [7:0] portOut,
  output logic [7:0] portOe,
  output logic sleeping
);
  localparam int SPW = $clog2(STACK_DEPTH);
  localparam int CW = $clog2(STACK_DEPTH + 1);

  // Depth must fit the four-bit status field
  if (STACK_DEPTH < 2 || STACK_DEPTH > 15) begin : g_bad_depth
    $error("STACK_DEPTH must be 2 to 15");
  end

  branch_ccr_pkg::instr_t ins, lastIns, next_lastIns;
  branch_ccr_pkg::state_t state, next_state;
  logic [15:0] pc, next_pc, target, next_target, excPc, next_excPc, pc2;
  logic [7:0] ccr, next_ccr, genReg, next_genReg, excCcr, next_excCcr;
  logic [7:0] rmwData, next_rmwData, ddrRead, drRead, ddrData;
  logic [2:0] rmwBit, next_rmwBit;
  logic rmwPort, next_rmwPort, lastTaken, next_lastTaken, next_sleeping;
  logic [CW-1:0] depth, next_depth;
  logic [15:0] stack [STACK_DEPTH];
  logic push, pop, condTrue, acc, wr, issue, ddrWe, drWe, rmwWrite;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  // Bus handshake terms and instruction acceptance
  always_comb begin
    acc = psel & penable & pready;
    wr = acc & pwrite;
    ins = branch_ccr_pkg::instr_t'(pwdata[$bits(branch_ccr_pkg::instr_t)-1:0]);
    pc2 = pc + branch_ccr_pkg::PC_STEP;
    issue = wr && paddr == branch_ccr_pkg::OFS_INSTR &&
      (state == branch_ccr_pkg::ST_IDLE ||
       (state == branch_ccr_pkg::ST_SLEEP && ins.op == branch_ccr_pkg::OP_TRAP));
    rmwWrite = state == branch_ccr_pkg::ST_WRITE;
    ddrWe = (wr && paddr == branch_ccr_pkg::OFS_PORTDDR) || (rmwWrite && rmwPort);
    ddrData = (rmwWrite && rmwPort) ? rmwData : pwdata[7:0];
    drWe = wr && paddr == branch_ccr_pkg::OFS_PORTDR;
  end

  cond_eval u_cond (
    .branchConditionField(ins.cond),
    .ccr(ccr),
    .taken(condTrue)
  );

  port_io_unit #(.W(8)) u_port (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ddrWe(ddrWe),
    .ddrData(ddrData),
    .drWe(drWe),
    .drData(pwdata[7:0]),
    .pinIn(portIn),
    .ddrRead(ddrRead),
    .drRead(drRead),
    .pinOut(portOut),
    .pinOe(portOe)
  );

  // Execution and register writes
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_target = target;
    next_ccr = ccr;
    next_genReg = genReg;
    next_excPc = excPc;
    next_excCcr = excCcr;
    next_rmwData = rmwData;
    next_rmwBit = rmwBit;
    next_rmwPort = rmwPort;
    next_lastTaken = lastTaken;
    next_lastIns = lastIns;
    next_depth = depth;
    push = 1'b0;
    pop = 1'b0;
    if (issue) begin
      next_lastIns = ins;
      case (ins.op)
        branch_ccr_pkg::OP_NOP: next_pc = pc2;
        branch_ccr_pkg::OP_BCC: begin
          next_pc = condTrue ? pc2 + target : pc2;
          next_lastTaken = condTrue;
        end
        branch_ccr_pkg::OP_JUMP: next_pc = target;
        branch_ccr_pkg::OP_CALL_ABS, branch_ccr_pkg::OP_CALL_REL: begin
          push = depth < CW'(STACK_DEPTH);
          next_pc = (ins.op == branch_ccr_pkg::OP_CALL_ABS) ? target : pc2 + target;
        end
        branch_ccr_pkg::OP_RTS: begin
          pop = depth != '0;
          next_pc = pop ? stack[SPW'(depth - CW'(1))] : pc2;
        end
        branch_ccr_pkg::OP_TRAP: begin
          next_excPc = pc2;
          next_excCcr = ccr;
          next_ccr[branch_ccr_pkg::CCR_I] = 1'b1;
          next_pc = target;
          next_state = branch_ccr_pkg::ST_IDLE;
        end
        branch_ccr_pkg::OP_EXC_RET: begin
          next_pc = excPc;
          next_ccr = excCcr;
        end
        branch_ccr_pkg::OP_SLEEP: begin
          next_pc = pc2;
          next_state = branch_ccr_pkg::ST_SLEEP;
        end
        branch_ccr_pkg::OP_LOADF_IMM: next_ccr = ins.imm;
        branch_ccr_pkg::OP_LOADF_REG: next_ccr = genReg;
        branch_ccr_pkg::OP_STOREF: next_genReg = ccr;
        branch_ccr_pkg::OP_ANDF: next_ccr = ccr & ins.imm;
        branch_ccr_pkg::OP_ORF: next_ccr = ccr | ins.imm;
        branch_ccr_pkg::OP_XORF: next_ccr = ccr ^ ins.imm;
        branch_ccr_pkg::OP_BITCLR: begin
          next_rmwBit = ins.bitNum;
          next_rmwPort = ins.toPort;
          next_state = branch_ccr_pkg::ST_READ;
        end
        default: next_pc = pc2;
      endcase
      if (ins.op != branch_ccr_pkg::OP_BITCLR && ins.op != branch_ccr_pkg::OP_SLEEP &&
          ins.op != branch_ccr_pkg::OP_TRAP) begin
        next_state = branch_ccr_pkg::ST_IDLE;
      end
    end else if (wr) begin
      case (paddr)
        branch_ccr_pkg::OFS_TARGET: next_target = pwdata[15:0];
        branch_ccr_pkg::OFS_PC: next_pc = pwdata[15:0];
        branch_ccr_pkg::OFS_CCR: next_ccr = pwdata[7:0];
        branch_ccr_pkg::OFS_GENREG: next_genReg = pwdata[7:0];
        default: next_target = target;
      endcase
    end
    // Read, modify, write sequence of bit clear
    case (state)
      branch_ccr_pkg::ST_READ: begin
        next_rmwData = rmwPort ? ddrRead : genReg;
        next_state = branch_ccr_pkg::ST_MODIFY;
      end
      branch_ccr_pkg::ST_MODIFY: begin
        next_rmwData = rmwData & ~(8'h01 << rmwBit);
        next_state = branch_ccr_pkg::ST_WRITE;
      end
      branch_ccr_pkg::ST_WRITE: begin
        if (!rmwPort) begin
          next_genReg = rmwData;
        end
        next_pc = pc2;
        next_state = branch_ccr_pkg::ST_IDLE;
      end
      default: next_rmwData = rmwData;
    endcase
    if (push) begin
      next_depth = depth + CW'(1);
    end else if (pop) begin
      next_depth = depth - CW'(1);
    end
    next_sleeping = next_state == branch_ccr_pkg::ST_SLEEP;
  end

  // Execution state registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= branch_ccr_pkg::ST_IDLE;
      pc <= branch_ccr_pkg::PC_RESET;
      target <= branch_ccr_pkg::PC_RESET;
      ccr <= branch_ccr_pkg::CCR_RESET;
      genReg <= '0;
      excPc <= branch_ccr_pkg::PC_RESET;
      excCcr <= branch_ccr_pkg::CCR_RESET;
      rmwData <= '0;
      rmwBit <= '0;
      rmwPort <= 1'b0;
      lastTaken <= 1'b0;
      lastIns <= '0;
      depth <= '0;
      sleeping <= 1'b0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      target <= next_target;
      ccr <= next_ccr;
      genReg <= next_genReg;
      excPc <= next_excPc;
      excCcr <= next_excCcr;
      rmwData <= next_rmwData;
      rmwBit <= next_rmwBit;
      rmwPort <= next_rmwPort;
      lastTaken <= next_lastTaken;
      lastIns <= next_lastIns;
      depth <= next_depth;
      sleeping <= next_sleeping;
    end
  end

  // Return point storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      stack[SPW'(depth)] <= pc2;
    end
  end

  // Bus answer: one wait cycle, registered data
  always_comb begin
    next_pready = psel & penable & !pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (next_pready) begin
      next_prdata = '0;
      case (paddr)
        branch_ccr_pkg::OFS_INSTR: next_prdata[19:0] = lastIns;
        branch_ccr_pkg::OFS_TARGET: next_prdata[15:0] = target;
        branch_ccr_pkg::OFS_PC: next_prdata[15:0] = pc;
        branch_ccr_pkg::OFS_CCR: next_prdata[7:0] = ccr;
        branch_ccr_pkg::OFS_GENREG: next_prdata[7:0] = genReg;
        branch_ccr_pkg::OFS_PORTDR: next_prdata[7:0] = drRead;
        branch_ccr_pkg::OFS_PORTDDR: next_prdata[7:0] = ddrRead;
        branch_ccr_pkg::OFS_STATUS: begin
          next_prdata[branch_ccr_pkg::ST_BUSY_BIT] = state != branch_ccr_pkg::ST_IDLE &&
            state != branch_ccr_pkg::ST_SLEEP;
          next_prdata[branch_ccr_pkg::ST_SLEEP_BIT] = sleeping;
          next_prdata[branch_ccr_pkg::ST_TAKEN_BIT] = lastTaken;
          next_prdata[branch_ccr_pkg::ST_DEPTH_LSB +: CW] = depth;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_ddr_reads_ones: assert property (
    psel && pready && !pwrite && paddr == branch_ccr_pkg::OFS_PORTDDR |-> prdata[7:0] == 8'hFF)
    else $error("direction register read not all ones");
  a_bit_clear_instr_one_bit: assert property (
    state == branch_ccr_pkg::ST_MODIFY |=> rmwData == ($past(rmwData) & ~(8'h01 << rmwBit)))
    else $error("bit clear changed wrong bits");
  a_bit_clear_instr_port_back: assert property (
    state == branch_ccr_pkg::ST_WRITE && rmwPort |=> portOe == $past(rmwData))
    else $error("bit clear did not write byte back");
  a_pin_direction: assert property (
    wr && paddr == branch_ccr_pkg::OFS_PORTDDR && state == branch_ccr_pkg::ST_IDLE
    |=> portOe == $past(pwdata[7:0]))
    else $error("direction write not seen on enables");
  a_branch_never: assert property (
    issue && ins.op == branch_ccr_pkg::OP_BCC && ins.cond == 4'h1 |=> pc == $past(pc2))
    else $error("never branch was taken");
  a_branch_carry: assert property (
    issue && ins.op == branch_ccr_pkg::OP_BCC && ins.cond == 4'h5 && ccr[branch_ccr_pkg::CCR_C]
    |=> pc == $past(pc2 + target) && lastTaken)
    else $error("carry set branch not taken");
  a_branch_signed: assert property (
    issue && ins.op == branch_ccr_pkg::OP_BCC && ins.cond == 4'hC &&
    (ccr[branch_ccr_pkg::CCR_N] != ccr[branch_ccr_pkg::CCR_V]) |=> !lastTaken)
    else $error("greater-equal taken with N xor V set");
  a_jump_target: assert property (
    issue && ins.op == branch_ccr_pkg::OP_JUMP |=> pc == $past(target))
    else $error("jump missed target");
  a_call_return: assert property (
    issue && ins.op == branch_ccr_pkg::OP_CALL_ABS && depth < CW'(STACK_DEPTH) ##1
    state == branch_ccr_pkg::ST_IDLE ##3 issue && ins.op == branch_ccr_pkg::OP_RTS
    |=> pc == $past(pc2, 5))
    else $error("return did not resume after call");
  a_sleep_enter: assert property (
    issue && ins.op == branch_ccr_pkg::OP_SLEEP |=> sleeping ##1 sleeping || $past(issue))
    else $error("sleep not entered");
  a_ccr_and: assert property (
    issue && ins.op == branch_ccr_pkg::OP_ANDF |=> ccr == ($past(ccr) & $past(ins.imm)))
    else $error("flags AND wrong");
  a_nop_pc: assert property (
    issue && ins.op == branch_ccr_pkg::OP_NOP |=> pc == $past(pc) + 16'h0002 && $stable(ccr))
    else $error("no-op changed more than pc");
  a_rmw_order: assert property (
    state == branch_ccr_pkg::ST_READ |=> state == branch_ccr_pkg::ST_MODIFY ##1
    state == branch_ccr_pkg::ST_WRITE ##1 state == branch_ccr_pkg::ST_IDLE)
    else $error("bit clear steps out of order");

  c_bit_clear_instr_port: cover property (state == branch_ccr_pkg::ST_WRITE && rmwPort);
  c_branch_taken: cover property (issue && ins.op == branch_ccr_pkg::OP_BCC && condTrue);
  c_sleep_wake: cover property (sleeping ##[1:100] !sleeping);
  c_call_ret: cover property (pop);
endmodule // branch_and_ccr_control_exec

// ### tb_branch_and_ccr_control_exec.sv
module tb_branch_and_ccr_control_exec;
  timeunit 1ns;
  timeprecision 1ps;

  logic sysClk;
  logic sysRst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] portIn;
  logic [7:0] portOut;
  logic [7:0] portOe;
  logic sleeping;
  logic lastErr;
  int errCount;
  int checkCount;

  branch_and_ccr_control_exec #(.STACK_DEPTH(8)) dut_u (
    .sys_clk(sysClk),
    .sys_rst(sysRst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .portIn(portIn),
    .portOut(portOut),
    .portOe(portOe),
    .sleeping(sleeping)
  );

  // Free-running system clock
  always #5 sysClk = ~sysClk;

  // Comparison with mismatch report
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sysClk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1'b1;
    do begin
      @(posedge sysClk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errCount++;
    end
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0000_0000, r);
  endtask

  // Issue one instruction and let it finish
  task automatic exec(input logic [3:0] op, input logic [3:0] cond, input logic [2:0] bitNum,
                      input logic toPort, input logic [7:0] imm);
    wr(branch_ccr_pkg::OFS_INSTR, {12'h000, imm, cond, bitNum, toPort, op});
    repeat (4) @(posedge sysClk);
  endtask

  // Expected branch decision from the flag nibble {N,Z,V,C}
  function automatic logic condExp(input logic [3:0] c, input logic [3:0] f);
    logic b;
    case (c[3:1])
      3'd0: b = 1'b0;
      3'd1: b = f[0] | f[2];
      3'd2: b = f[0];
      3'd3: b = f[2];
      3'd4: b = f[1];
      3'd5: b = f[3];
      3'd6: b = f[3] ^ f[1];
      default: b = f[2] | (f[3] ^ f[1]);
    endcase
    return b == c[0];
  endfunction

  // Reset values, write-only direction read, pins and bit clear on the port
  task automatic portScenario();
    logic [31:0] r;
    chk("oeReset", portOe, 8'h00);
    rd(branch_ccr_pkg::OFS_CCR, r);
    chk("ccrReset", r, 32'h0000_0080);
    wr(branch_ccr_pkg::OFS_PORTDDR, 32'h0000_003F);
    wr(branch_ccr_pkg::OFS_PORTDR, 32'h0000_0080);
    wr(branch_ccr_pkg::OFS_PC, 32'h0000_0100);
    repeat (3) @(posedge sysClk);
    chk("oe", portOe, 8'h3F);
    chk("drivenBits", portOut & portOe, 8'h00);
    rd(branch_ccr_pkg::OFS_PORTDR, r);
    chk("drRead", r, 32'h0000_0040);
    rd(branch_ccr_pkg::OFS_PORTDDR, r);
    chk("ddrRead", r, 32'h0000_00FF);
    exec(branch_ccr_pkg::OP_BITCLR, 4'h0, 3'd0, 1'b1, 8'h00);
    chk("oeAfterClear", portOe, 8'hFE);
    chk("drivenAfter", portOut & portOe, 8'h80);
    rd(branch_ccr_pkg::OFS_PORTDDR, r);
    chk("ddrStillOnes", r, 32'h0000_00FF);
    wr(branch_ccr_pkg::OFS_GENREG, 32'h0000_00A5);
    exec(branch_ccr_pkg::OP_BITCLR, 4'h0, 3'd7, 1'b0, 8'h00);
    rd(branch_ccr_pkg::OFS_GENREG, r);
    chk("genClear", r, 32'h0000_0025);
    chk("oeUntouched", portOe, 8'hFE);
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("pcAfterClears", r, 32'h0000_0104);
  endtask

  // Every condition code against every flag combination
  task automatic branchScenario();
    logic [31:0] r;
    logic [31:0] e;
    logic t;
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 16; f++) begin
        wr(branch_ccr_pkg::OFS_CCR, {28'h000_0000, f[3:0]});
        wr(branch_ccr_pkg::OFS_PC, 32'h0000_0100);
        wr(branch_ccr_pkg::OFS_TARGET, 32'h0000_0010);
        exec(branch_ccr_pkg::OP_BCC, c[3:0], 3'd0, 1'b0, 8'h00);
        rd(branch_ccr_pkg::OFS_PC, r);
        t = condExp(c[3:0], f[3:0]);
        e = t ? 32'h0000_0112 : 32'h0000_0102;
        if (c < 4) chk("branchPc", r, e);
        else if (c < 12) chk("branchPc", r, e);
        else chk("branchPc", r, e);
      end
    end
  endtask

  // Jump, calls and returns
  task automatic callScenario();
    logic [31:0] r;
    wr(branch_ccr_pkg::OFS_CCR, 32'h0000_000F);
    wr(branch_ccr_pkg::OFS_PC, 32'h0000_0100);
    wr(branch_ccr_pkg::OFS_TARGET, 32'h0000_1234);
    exec(branch_ccr_pkg::OP_JUMP, 4'h1, 3'd0, 1'b0, 8'h00);
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("jumpPc", r, 32'h0000_1234);
    wr(branch_ccr_pkg::OFS_PC, 32'h0000_0200);
    wr(branch_ccr_pkg::OFS_TARGET, 32'h0000_3000);
    exec(branch_ccr_pkg::OP_CALL_ABS, 4'h0, 3'd0, 1'b0, 8'h00);
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("absCallPc", r, 32'h0000_3000);
    wr(branch_ccr_pkg::OFS_TARGET, 32'h0000_0010);
    exec(branch_ccr_pkg::OP_CALL_REL, 4'h0, 3'd0, 1'b0, 8'h00);
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("relCallPc", r, 32'h0000_3012);
    rd(branch_ccr_pkg::OFS_STATUS, r);
    chk("depth", r[7:4], 32'h0000_0002);
    exec(branch_ccr_pkg::OP_RTS, 4'h0, 3'd0, 1'b0, 8'h00);
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("innerReturn", r, 32'h0000_3002);
    exec(branch_ccr_pkg::OP_RTS, 4'h0, 3'd0, 1'b0, 8'h00);
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("outerReturn", r, 32'h0000_0202);
    // Call and return issued back to back
    wr(branch_ccr_pkg::OFS_PC, 32'h0000_0300);
    wr(branch_ccr_pkg::OFS_INSTR, {28'h000_0000, branch_ccr_pkg::OP_CALL_ABS});
    wr(branch_ccr_pkg::OFS_INSTR, {28'h000_0000, branch_ccr_pkg::OP_RTS});
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("quickReturn", r, 32'h0000_0302);
  endtask

  // Exception entry and return, then sleep and wake
  task automatic systemScenario();
    logic [31:0] r;
    wr(branch_ccr_pkg::OFS_CCR, 32'h0000_0005);
    wr(branch_ccr_pkg::OFS_PC, 32'h0000_0400);
    wr(branch_ccr_pkg::OFS_TARGET, 32'h0000_0800);
    exec(branch_ccr_pkg::OP_TRAP, 4'h0, 3'd0, 1'b0, 8'h00);
    wr(branch_ccr_pkg::OFS_CCR, 32'h0000_000A);
    exec(branch_ccr_pkg::OP_EXC_RET, 4'h0, 3'd0, 1'b0, 8'h00);
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("rtePc", r, 32'h0000_0402);
    rd(branch_ccr_pkg::OFS_CCR, r);
    chk("rteFlags", r, 32'h0000_0005);
    exec(branch_ccr_pkg::OP_SLEEP, 4'h0, 3'd0, 1'b0, 8'h00);
    chk("asleep", sleeping, 1'b1);
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("sleepPc", r, 32'h0000_0404);
    exec(branch_ccr_pkg::OP_NOP, 4'h0, 3'd0, 1'b0, 8'h00);
    chk("stillAsleep", sleeping, 1'b1);
    rd(branch_ccr_pkg::OFS_STATUS, r);
    chk("statusSleep", r[1], 1'b1);
    exec(branch_ccr_pkg::OP_TRAP, 4'h0, 3'd0, 1'b0, 8'h00);
    chk("awake", sleeping, 1'b0);
  endtask

  // Flag register transfers and logic, then no-operation
  task automatic flagScenario();
    logic [31:0] r;
    logic [31:0] p;
    exec(branch_ccr_pkg::OP_LOADF_IMM, 4'h0, 3'd0, 1'b0, 8'h5A);
    rd(branch_ccr_pkg::OFS_CCR, r);
    chk("loadImm", r, 32'h0000_005A);
    wr(branch_ccr_pkg::OFS_GENREG, 32'h0000_00C3);
    exec(branch_ccr_pkg::OP_LOADF_REG, 4'h0, 3'd0, 1'b0, 8'h00);
    rd(branch_ccr_pkg::OFS_CCR, r);
    chk("loadReg", r, 32'h0000_00C3);
    exec(branch_ccr_pkg::OP_ANDF, 4'h0, 3'd0, 1'b0, 8'h0F);
    rd(branch_ccr_pkg::OFS_CCR, r);
    chk("andFlags", r, 32'h0000_0003);
    exec(branch_ccr_pkg::OP_ORF, 4'h0, 3'd0, 1'b0, 8'h50);
    rd(branch_ccr_pkg::OFS_CCR, r);
    chk("orFlags", r, 32'h0000_0053);
    exec(branch_ccr_pkg::OP_XORF, 4'h0, 3'd0, 1'b0, 8'hFF);
    rd(branch_ccr_pkg::OFS_CCR, r);
    chk("xorFlags", r, 32'h0000_00AC);
    exec(branch_ccr_pkg::OP_STOREF, 4'h0, 3'd0, 1'b0, 8'h00);
    rd(branch_ccr_pkg::OFS_GENREG, r);
    chk("storeFlags", r, 32'h0000_00AC);
    rd(branch_ccr_pkg::OFS_PC, p);
    exec(branch_ccr_pkg::OP_NOP, 4'h0, 3'd0, 1'b0, 8'hFF);
    rd(branch_ccr_pkg::OFS_PC, r);
    chk("nopPc", r, p + 32'h0000_0002);
    rd(branch_ccr_pkg::OFS_CCR, r);
    chk("nopFlags", r, 32'h0000_00AC);
    rd(8'h20, r);
    chk("unmappedErr", lastErr, 1'b1);
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge sysClk);
    errCount++;
    summarize();
  end

  // Main sequence
  initial begin
    sysClk = 1'b0;
    sysRst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    portIn = 8'h40;
    lastErr = 1'b0;
    errCount = 0;
    checkCount = 0;
    repeat (10) @(posedge sysClk);
    sysRst <= 1'b0;
    @(posedge sysClk);
    portScenario();
    branchScenario();
    callScenario();
    systemScenario();
    flagScenario();
    summarize();
  end
endmodule // tb_branch_and_ccr_control_exec
